// File: rtl/fmsp_defines.svh
// Register map, field positions and timing counts of the serial port
`ifndef FMSP_DEFINES_SVH
`define FMSP_DEFINES_SVH

`define FMSP_ADDR_CTRL 8'h98
`define FMSP_ADDR_BUF 8'h99
`define FMSP_CTRL_RESET 8'h00

`define FMSP_B_MODE_HI 7
`define FMSP_B_MODE_LO 6
`define FMSP_B_MP 5
`define FMSP_B_REN 4
`define FMSP_B_TB8 3
`define FMSP_B_RB8 2
`define FMSP_B_TI 1
`define FMSP_B_RI 0

// Sync mode: 12 clocks per bit, shift clock rises at phase 6
`define FMSP_M0_LAST 4'hB
`define FMSP_M0_HIGH 4'h6
// Async: 16 oversample ticks per bit
`define FMSP_OVS_LAST 4'hF
`define FMSP_OVS_MID 4'h7
// Fixed-rate 9-bit: tick every 4 clocks (1/64) or every 2 clocks (1/32)
`define FMSP_DIV64_LAST 2'h3
`define FMSP_DIV32_LAST 2'h1
// Frame lengths: transmit counts all bits, receive counts bits after start
`define FMSP_TX_LEN9 4'hB
`define FMSP_TX_LEN8 4'hA
`define FMSP_RX_LEN9 4'hA
`define FMSP_RX_LEN8 4'h9

`endif

// File: rtl/fmsp_pkg.sv
// Types shared by the serial port modules
package fmsp_pkg;

    typedef enum logic [1:0] {
        FMSP_SYNC = 2'h0,
        FMSP_ASYNC8 = 2'h1,
        FMSP_FIXED9 = 2'h2,
        FMSP_VAR9 = 2'h3
    } fmsp_mode_t;

    typedef enum logic [1:0] {
        FMSP_TX_IDLE = 2'h0,
        FMSP_TX_ASYNC = 2'h1,
        FMSP_TX_SYNC = 2'h3,
        FMSP_TX_SYNC_RX = 2'h2
    } fmsp_tx_state_t;

    typedef enum logic [1:0] {
        FMSP_RX_IDLE = 2'h0,
        FMSP_RX_START = 2'h1,
        FMSP_RX_DATA = 2'h3,
        FMSP_RX_UNUSED = 2'h2
    } fmsp_rx_state_t;

endpackage : fmsp_pkg

// File: rtl/fmsp_sync.sv
// Two flip-flop level synchroniser with a chosen reset value
`timescale 1ns/10ps
`default_nettype none

module fmsp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output var logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_reg <= RST_VAL;
            q <= RST_VAL;
        end
        else
        begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule : fmsp_sync

`default_nettype wire

// File: rtl/fmsp_link_io.sv
// Pin-facing logic of the serial port on the link clock
`timescale 1ns/10ps
`default_nettype none

module fmsp_link_io (
    input wire logic link_clk,
    input wire logic link_rst,
    input wire logic txd_lvl,
    input wire logic rxo_lvl,
    input wire logic rxoe_lvl,
    input wire logic rxd_in,
    output logic txd,
    output logic rxd_out,
    output logic rxd_oe,
    output logic rxd_link
);
    // Line levels from the core cross as levels; txd idles high
    fmsp_sync #(.W(3), .RST_VAL(3'h4)) u_out_sync (
        .clk(link_clk),
        .rst(link_rst),
        .d({txd_lvl, rxo_lvl, rxoe_lvl}),
        .q({txd, rxd_out, rxd_oe})
    );

    fmsp_sync #(.W(1), .RST_VAL(1'h1)) u_in_sync (
        .clk(link_clk),
        .rst(link_rst),
        .d(rxd_in),
        .q(rxd_link)
    );
endmodule : fmsp_link_io

`default_nettype wire

// File: rtl/fmsp_port.sv
// Four-mode serial port: control register, data buffer, shift engines
//
// Functional notes
// - Mode bits high first: sync, 8-bit, 9-bit fixed, 9-bit variable
// - Sync mode: data on rxd, clock on txd
// - Sync mode: eight bits, LSB first, clock/12
// - 8-bit async: start, eight data, stop bit
// - 8-bit async: stop level goes to rx ninth
// - Modes 1 and 3 timed by baud tick
// - 9-bit modes send start, data, ninth, stop
// - 9-bit modes store ninth bit, drop stop
// - Fixed 9-bit mode runs at clock/32 or /64
// - Rate select clear gives /64, set /32
// - Variable 9-bit mode mirrors fixed, tick-timed
// - Any buffer write starts a transmission
// - Separate receive register; unread byte overwritten
// - Sync receive starts when done clear, enabled
// - Async receive starts on start bit if enabled
// - Multiprocessor filter: 9-bit done needs ninth high
// - 8-bit mode filter: done needs high stop
// - Tx ninth unused modes 0/1; rx ninth untouched mode 0
// - Tx done at 8th bit or stop start
// - Rx done at 8th bit or mid stop
`timescale 1ns/10ps
`default_nettype none
`include "fmsp_defines.svh"

module fmsp_port (
    input wire logic mclk,
    input wire logic rst,
    input wire logic link_clk,
    input wire logic link_rst,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    input wire logic rate_double_select,
    input wire logic baud_tick,
    input wire logic rxd_in,
    output logic rxd_out,
    output logic rxd_oe,
    output logic txd,
    output logic serial_irq
);
    import fmsp_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [7:0] ctrl_reg, ctrl_next;
    logic [7:0] rxbuf_reg, rxbuf_next;
    logic [7:0] rdata_reg, rdata_next;
    logic irq_reg, irq_next;
    logic [1:0] div_reg, div_next;
    fmsp_tx_state_t tx_st_reg, tx_st_next;
    logic [10:0] tx_sh_reg, tx_sh_next;
    logic [3:0] tx_left_reg, tx_left_next;
    logic [3:0] tx_os_reg, tx_os_next;
    logic [3:0] ph_reg, ph_next;
    logic [2:0] m0bit_reg, m0bit_next;
    logic txd_reg, txd_next;
    logic rxo_reg, rxo_next;
    logic rxoe_reg, rxoe_next;
    fmsp_rx_state_t rx_st_reg, rx_st_next;
    logic [9:0] rx_sh_reg, rx_sh_next;
    logic [3:0] rx_left_reg, rx_left_next;
    logic [3:0] rx_os_reg, rx_os_next;
    logic rx_prev_reg, rx_prev_next;
    logic rxd_link, rxd_s;
    fmsp_mode_t mode;
    logic nine, mp, ren, os_tick, wr_ctrl, wr_buf;
    logic ti_set, m0_ri_set, a_ri_set, a_rb8;
    logic [7:0] a_byte;

    assign mode = fmsp_mode_t'(ctrl_reg[`FMSP_B_MODE_HI:`FMSP_B_MODE_LO]);
    assign nine = ctrl_reg[`FMSP_B_MODE_HI];
    assign mp = ctrl_reg[`FMSP_B_MP];
    assign ren = ctrl_reg[`FMSP_B_REN];
    assign wr_ctrl = sfr_wr && (sfr_addr == `FMSP_ADDR_CTRL);
    assign wr_buf = sfr_wr && (sfr_addr == `FMSP_ADDR_BUF);

    // ------------------------------------------------------------
    // Link side and receive line synchroniser
    // ------------------------------------------------------------
    fmsp_link_io u_link (
        .link_clk(link_clk),
        .link_rst(link_rst),
        .txd_lvl(txd_reg),
        .rxo_lvl(rxo_reg),
        .rxoe_lvl(rxoe_reg),
        .rxd_in(rxd_in),
        .txd(txd),
        .rxd_out(rxd_out),
        .rxd_oe(rxd_oe),
        .rxd_link(rxd_link)
    );

    fmsp_sync #(.W(1), .RST_VAL(1'h1)) u_rxd_sync (
        .clk(mclk),
        .rst(rst),
        .d(rxd_link),
        .q(rxd_s)
    );

    // ------------------------------------------------------------
    // Oversample tick: 16 per bit in all async modes
    // ------------------------------------------------------------
    always_comb
    begin
        logic [1:0] last;
        last = rate_double_select ? `FMSP_DIV32_LAST : `FMSP_DIV64_LAST;
        div_next = (div_reg == last) ? 2'h0 : div_reg + 2'h1;
        if (mode == FMSP_FIXED9)
            os_tick = (div_reg == last);
        else
            os_tick = baud_tick;
    end

    // ------------------------------------------------------------
    // Transmitter and sync-mode shifter
    // ------------------------------------------------------------
    always_comb
    begin
        tx_st_next = tx_st_reg;
        tx_sh_next = tx_sh_reg;
        tx_left_next = tx_left_reg;
        tx_os_next = tx_os_reg;
        ph_next = ph_reg;
        m0bit_next = m0bit_reg;
        txd_next = txd_reg;
        rxo_next = rxo_reg;
        rxoe_next = rxoe_reg;
        ti_set = 1'b0;
        m0_ri_set = 1'b0;
        if (wr_buf)
        begin
            ph_next = 4'h0;
            m0bit_next = 3'h0;
            tx_os_next = 4'h0;
            if (mode == FMSP_SYNC)
            begin
                tx_st_next = FMSP_TX_SYNC;
                tx_sh_next = {3'h7, sfr_wdata};
            end
            else if (nine)
            begin
                tx_st_next = FMSP_TX_ASYNC;
                tx_sh_next = {1'b1, ctrl_reg[`FMSP_B_TB8], sfr_wdata, 1'b0};
                tx_left_next = `FMSP_TX_LEN9;
                txd_next = 1'b0;
            end
            else
            begin
                tx_st_next = FMSP_TX_ASYNC;
                tx_sh_next = {2'h3, sfr_wdata, 1'b0};
                tx_left_next = `FMSP_TX_LEN8;
                txd_next = 1'b0;
            end
        end
        else
        begin
            unique case (tx_st_reg)
                FMSP_TX_IDLE:
                begin
                    txd_next = 1'b1;
                    rxoe_next = 1'b0;
                    if (mode == FMSP_SYNC && ren && !ctrl_reg[`FMSP_B_RI])
                    begin
                        tx_st_next = FMSP_TX_SYNC_RX;
                        ph_next = 4'h0;
                        m0bit_next = 3'h0;
                    end
                end
                FMSP_TX_ASYNC:
                begin
                    if (os_tick)
                    begin
                        tx_os_next = tx_os_reg + 4'h1;
                        if (tx_os_reg == `FMSP_OVS_LAST)
                        begin
                            tx_sh_next = {1'b1, tx_sh_reg[10:1]};
                            tx_left_next = tx_left_reg - 4'h1;
                            if (tx_left_reg == 4'h2)
                                ti_set = 1'b1;
                            if (tx_left_reg == 4'h1)
                                tx_st_next = FMSP_TX_IDLE;
                        end
                    end
                    txd_next = tx_sh_next[0];
                end
                FMSP_TX_SYNC, FMSP_TX_SYNC_RX:
                begin
                    // Clock low for phases 0..5, high for 6..11
                    ph_next = (ph_reg == `FMSP_M0_LAST) ? 4'h0 : ph_reg + 4'h1;
                    if (ph_reg == 4'h0)
                    begin
                        txd_next = 1'b0;
                        if (tx_st_reg == FMSP_TX_SYNC)
                        begin
                            rxo_next = tx_sh_reg[0];
                            rxoe_next = 1'b1;
                        end
                    end
                    if (ph_reg == `FMSP_M0_HIGH)
                    begin
                        txd_next = 1'b1;
                        if (tx_st_reg == FMSP_TX_SYNC_RX)
                            tx_sh_next = {tx_sh_reg[10:8], rxd_s, tx_sh_reg[7:1]};
                    end
                    if (ph_reg == `FMSP_M0_LAST)
                    begin
                        m0bit_next = m0bit_reg + 3'h1;
                        if (tx_st_reg == FMSP_TX_SYNC)
                            tx_sh_next = {1'b1, tx_sh_reg[10:1]};
                        if (m0bit_reg == 3'h7)
                        begin
                            tx_st_next = FMSP_TX_IDLE;
                            rxoe_next = 1'b0;
                            if (tx_st_reg == FMSP_TX_SYNC)
                                ti_set = 1'b1;
                            else
                                m0_ri_set = 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Asynchronous receiver
    // ------------------------------------------------------------
    always_comb
    begin
        rx_st_next = rx_st_reg;
        rx_sh_next = rx_sh_reg;
        rx_left_next = rx_left_reg;
        rx_os_next = rx_os_reg;
        rx_prev_next = rxd_s;
        a_ri_set = 1'b0;
        a_rb8 = 1'b0;
        a_byte = 8'h00;
        if (!ren || mode == FMSP_SYNC)
            rx_st_next = FMSP_RX_IDLE;
        else
        begin
            unique case (rx_st_reg)
                FMSP_RX_IDLE:
                begin
                    if (rx_prev_reg && !rxd_s)
                    begin
                        rx_st_next = FMSP_RX_START;
                        rx_os_next = 4'h0;
                    end
                end
                FMSP_RX_START:
                begin
                    if (os_tick)
                    begin
                        rx_os_next = rx_os_reg + 4'h1;
                        if (rx_os_reg == `FMSP_OVS_MID)
                        begin
                            // A glitch shorter than half a bit is not a start
                            rx_os_next = 4'h0;
                            rx_st_next = rxd_s ? FMSP_RX_IDLE : FMSP_RX_DATA;
                            rx_left_next = nine ? `FMSP_RX_LEN9 : `FMSP_RX_LEN8;
                        end
                    end
                end
                FMSP_RX_DATA:
                begin
                    if (os_tick)
                    begin
                        rx_os_next = rx_os_reg + 4'h1;
                        if (rx_os_reg == `FMSP_OVS_LAST)
                        begin
                            rx_sh_next = {rxd_s, rx_sh_reg[9:1]};
                            rx_left_next = rx_left_reg - 4'h1;
                            if (rx_left_reg == 4'h1)
                            begin
                                rx_st_next = FMSP_RX_IDLE;
                                a_byte = nine ? rx_sh_next[7:0] : rx_sh_next[8:1];
                                // Stop level in 8-bit mode, ninth bit otherwise
                                a_rb8 = nine ? rx_sh_next[8] : rx_sh_next[9];
                                a_ri_set = !mp || a_rb8;
                            end
                        end
                    end
                end
                FMSP_RX_UNUSED:
                    rx_st_next = FMSP_RX_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers seen by software
    // ------------------------------------------------------------
    always_comb
    begin
        ctrl_next = wr_ctrl ? sfr_wdata : ctrl_reg;
        rxbuf_next = rxbuf_reg;
        // Hardware events win over a same-cycle software clear
        if (ti_set)
            ctrl_next[`FMSP_B_TI] = 1'b1;
        if (m0_ri_set)
        begin
            ctrl_next[`FMSP_B_RI] = 1'b1;
            rxbuf_next = tx_sh_next[7:0];
        end
        if (a_ri_set)
        begin
            // An unread byte is simply replaced
            ctrl_next[`FMSP_B_RI] = 1'b1;
            ctrl_next[`FMSP_B_RB8] = a_rb8;
            rxbuf_next = a_byte;
        end
        rdata_next = rdata_reg;
        if (sfr_rd)
        begin
            if (sfr_addr == `FMSP_ADDR_CTRL)
                rdata_next = ctrl_reg;
            else if (sfr_addr == `FMSP_ADDR_BUF)
                rdata_next = rxbuf_reg;
            else
                rdata_next = 8'h00;
        end
        irq_next = ctrl_next[`FMSP_B_TI] || ctrl_next[`FMSP_B_RI];
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            ctrl_reg <= `FMSP_CTRL_RESET;
            rxbuf_reg <= 8'h00;
            rdata_reg <= 8'h00;
            irq_reg <= 1'b0;
            div_reg <= 2'h0;
            tx_st_reg <= FMSP_TX_IDLE;
            tx_sh_reg <= 11'h7FF;
            tx_left_reg <= 4'h0;
            tx_os_reg <= 4'h0;
            ph_reg <= 4'h0;
            m0bit_reg <= 3'h0;
            txd_reg <= 1'b1;
            rxo_reg <= 1'b0;
            rxoe_reg <= 1'b0;
            rx_st_reg <= FMSP_RX_IDLE;
            rx_sh_reg <= 10'h000;
            rx_left_reg <= 4'h0;
            rx_os_reg <= 4'h0;
            rx_prev_reg <= 1'b1;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            rxbuf_reg <= rxbuf_next;
            rdata_reg <= rdata_next;
            irq_reg <= irq_next;
            div_reg <= div_next;
            tx_st_reg <= tx_st_next;
            tx_sh_reg <= tx_sh_next;
            tx_left_reg <= tx_left_next;
            tx_os_reg <= tx_os_next;
            ph_reg <= ph_next;
            m0bit_reg <= m0bit_next;
            txd_reg <= txd_next;
            rxo_reg <= rxo_next;
            rxoe_reg <= rxoe_next;
            rx_st_reg <= rx_st_next;
            rx_sh_reg <= rx_sh_next;
            rx_left_reg <= rx_left_next;
            rx_os_reg <= rx_os_next;
            rx_prev_reg <= rx_prev_next;
        end
    end

    assign sfr_rdata = rdata_reg;
    assign serial_irq = irq_reg;
endmodule : fmsp_port

`default_nettype wire

// File: test/fmsp_port_chk.sv
// Port-level assertions for the four-mode serial port
`timescale 1ns/10ps
`default_nettype none

module fmsp_port_chk (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_rdata,
    input wire logic rate_double_select,
    input wire logic baud_tick,
    input wire logic rxd_oe,
    input wire logic txd,
    input wire logic serial_irq
);
    logic ctl_wr, buf_wr, age_ok;
    logic [7:0] ctl_reg;
    logic [5:0] ctl_age;
    logic [10:0] wr_age, tk_age, oe_len;
    logic [3:0] ctx;

    // ----
    // Shadow of software writes and frame timers
    // ----
    assign ctl_wr = sfr_wr && sfr_addr == 8'h98;
    assign buf_wr = sfr_wr && sfr_addr == 8'h99;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            ctl_reg <= 8'h00;
            ctl_age <= 6'h00;
            wr_age <= 11'h7FF;
            tk_age <= 11'h000;
            ctx <= 4'h1;
            oe_len <= 11'h000;
        end
        else
        begin
            ctl_reg <= ctl_wr ? sfr_wdata : ctl_reg;
            ctl_age <= ctl_wr ? 6'h00 : ctl_age + {5'h00, ctl_age != 6'h3F};
            wr_age <= buf_wr ? 11'h000 : wr_age + {10'h000, wr_age != 11'h7FF};
            tk_age <= buf_wr ? 11'h000 : tk_age + {10'h000, baud_tick};
            ctx <= buf_wr ? {ctl_reg[7:6], rate_double_select, serial_irq} : ctx;
            oe_len <= rxd_oe ? oe_len + 11'h001 : 11'h000;
        end
    end

    // Tick-timed modes are judged in ticks, so the tick rate stays free
    always_comb
    begin
        case (ctx[3:1])
            3'h0, 3'h1: age_ok = wr_age >= 11'h05E && wr_age <= 11'h064;
            3'h2, 3'h3: age_ok = tk_age >= 11'h08F && tk_age <= 11'h092;
            3'h4: age_ok = wr_age >= 11'h27B && wr_age <= 11'h288;
            3'h5: age_ok = wr_age >= 11'h13C && wr_age <= 11'h146;
            default: age_ok = tk_age >= 11'h09F && tk_age <= 11'h0A2;
        endcase
    end

    // ----
    // Assertions
    // ----
    reset_values_a: assert property (@(posedge mclk) disable iff (rst)
        $fell(rst) |-> sfr_rdata == 8'h00 && !serial_irq)
        else $error("outputs not at reset value");
    unmapped_read_a: assert property (@(posedge mclk) disable iff (rst)
        sfr_rd && sfr_addr != 8'h98 && sfr_addr != 8'h99 |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    ctrl_readback_a: assert property (@(posedge mclk) disable iff (rst)
        ctl_wr ##2 (sfr_rd && sfr_addr == 8'h98 && !sfr_wr && !$past(sfr_wr))
        |=> sfr_rdata[7:3] == $past(sfr_wdata[7:3], 3))
        else $error("control fields not read back");
    sync_oe_only_a: assert property (@(posedge mclk) disable iff (rst)
        ctl_reg[7:6] != 2'h0 && ctl_age == 6'h3F |-> !rxd_oe)
        else $error("data pin driven outside sync mode");
    oe_burst_a: assert property (@(posedge mclk) disable iff (rst)
        $fell(rxd_oe) |-> oe_len >= 11'h05B && oe_len <= 11'h065)
        else $error("sync drive window not eight bit times");
    tx_done_time_a: assert property (@(posedge mclk) disable iff (rst)
        $rose(serial_irq) && !ctx[0] && wr_age != 11'h7FF |-> age_ok)
        else $error("transmit done at wrong time");
    irq_sticky_a: assert property (@(posedge mclk) disable iff (rst)
        serial_irq && !ctl_wr && !$past(ctl_wr) |=> serial_irq)
        else $error("done flag cleared without software");
    txd_idle_a: assert property (@(posedge mclk) disable iff (rst)
        wr_age == 11'h7FF && ctl_age == 6'h3F && !(ctl_reg[7:6] == 2'h0 && ctl_reg[4])
        |-> txd)
        else $error("transmit pin not idle high");
endmodule : fmsp_port_chk

bind fmsp_port fmsp_port_chk fmsp_port_chk_i (.mclk, .rst, .sfr_addr, .sfr_wdata, .sfr_wr,
    .sfr_rd, .sfr_rdata, .rate_double_select, .baud_tick, .rxd_oe, .txd, .serial_irq);

`default_nettype wire

// File: test/fmsp_remote_node.sv
// Far-side model: async node and sync shift register
`timescale 1ns/10ps
`default_nettype none

module fmsp_remote_node (
    input wire logic mclk,
    input wire logic txd,
    input wire logic rxd_line,
    output var logic line_out
);
    // Idle line sits high, as a pulled-up serial line would
    initial line_out = 1'b1;

    task automatic send_char(input logic [7:0] d, input logic nine, input logic b9,
        input logic stop, input int bc);
        logic [10:0] f;
        f = nine ? {stop, b9, d, 1'b0} : {1'b1, stop, d, 1'b0};
        for (int i = 0; i < (nine ? 11 : 10); i++)
        begin
            line_out <= f[i];
            repeat (bc) @(posedge mclk);
        end
        line_out <= 1'b1;
        // Idle edge keeps back-to-back frames from double-driving the line
        @(posedge mclk);
    endtask : send_char

    // Static level, as a shift register with constant contents
    task automatic hold_level(input logic v);
        line_out <= v;
    endtask : hold_level

    // Samples each bit at its centre, start bit included
    task automatic recv_char(input int nb, input int bc, output logic [10:0] v);
        v = 11'h7FF;
        @(negedge txd);
        repeat (bc / 2) @(posedge mclk);
        for (int i = 0; i < nb; i++)
        begin
            v[i] = txd;
            repeat (bc) @(posedge mclk);
        end
    endtask : recv_char

    task automatic sync_take(output logic [7:0] v);
        for (int i = 0; i < 8; i++)
        begin
            @(posedge txd);
            v[i] = rxd_line;
        end
    endtask : sync_take
endmodule : fmsp_remote_node

`default_nettype wire

// File: test/fmsp_port_tb_top.sv
// Self-checking bench of the serial port
`timescale 1ns/10ps
`default_nettype none

module fmsp_port_tb_top;
    logic mclk = 1'b0, rst = 1'b1, link_clk = 1'b0, link_rst = 1'b1;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
    logic sfr_wr = 1'b0, sfr_rd = 1'b0, rate_double_select = 1'b0, baud_tick = 1'b0;
    logic rxd_in, rxd_out, rxd_oe, txd, serial_irq, node_line;
    logic [1:0] tick_cnt = 2'h0;
    logic [7:0] r, d, c, last_rx;
    logic [10:0] f;
    logic nine, rb, ok;
    int bc, seed, num_errors = 0, total_checks = 0;
    logic [7:0] cfg [0:9] = '{8'h25, 8'h2C, 8'h2D, 8'h55, 8'h4D, 8'h4F, 8'h67, 8'h6D,
        8'h21, 8'hA5};

    always #12.5 mclk = ~mclk;
    initial
    begin
        #7;
        forever #62.5 link_clk = ~link_clk;
    end
    // Timer overflow stand-in: one tick every four clocks
    always @(posedge mclk)
    begin
        tick_cnt <= tick_cnt + 2'h1;
        baud_tick <= tick_cnt == 2'h3;
    end
    assign rxd_in = rxd_oe ? rxd_out : node_line;

    fmsp_port fmsp_port_i (.mclk, .rst, .link_clk, .link_rst, .sfr_addr, .sfr_wdata, .sfr_wr,
        .sfr_rd, .sfr_rdata, .rate_double_select, .baud_tick, .rxd_in, .rxd_out, .rxd_oe,
        .txd, .serial_irq);
    fmsp_remote_node fmsp_remote_node_i (.mclk, .txd, .rxd_line(rxd_in), .line_out(node_line));

    // ----
    // Bus and compare tasks
    // ----
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        sfr_addr <= a;
        sfr_wdata <= v;
        sfr_wr <= 1'b1;
        @(posedge mclk);
        sfr_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge mclk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge mclk);
        sfr_rd <= 1'b0;
        #1;
        v = sfr_rdata;
    endtask : rd

    task automatic chk(input string n, input logic [10:0] e, input logic [10:0] g);
        total_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    function automatic logic [10:0] exp_frame(input logic [7:0] v, input logic n9,
        input logic b9);
        return n9 ? {1'b1, b9, v, 1'b0} : {2'h3, v, 1'b0};
    endfunction : exp_frame

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test

    // ----
    // Scenarios
    // ----
    initial
    begin
        seed = 88975;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        // Pin side needs two link clock edges of reset
        repeat (7) @(posedge mclk);
        link_rst <= 1'b0;
        rd(8'h98, r);
        chk("ctrl reset", 11'h000, r);
        d = 8'($random(seed)) & 8'hEC;
        wr(8'h98, d);
        rd(8'h98, r);
        chk("ctrl readback", d, r);
        rd(8'h5A, r);
        chk("unmapped read", 11'h000, r);
        $display("test registers done");
        // Line held low so stale shifter ones cannot pass as data
        fmsp_remote_node_i.hold_level(1'b0);
        repeat (20) @(posedge mclk);
        wr(8'h98, 8'h14);
        fmsp_remote_node_i.sync_take(r);
        repeat (30) @(posedge mclk);
        rd(8'h98, r);
        chk("sync rx ctrl", 11'h015, r);
        rd(8'h99, r);
        chk("sync rx data", 11'h000, r);
        last_rx = 8'h00;
        fmsp_remote_node_i.hold_level(1'b1);
        $display("test sync receive done");
        wr(8'h98, 8'h00);
        d = 8'($random(seed));
        fork
            wr(8'h99, d);
            fmsp_remote_node_i.sync_take(r);
        join
        chk("sync tx data", d, r);
        repeat (30) @(posedge mclk);
        rd(8'h98, r);
        chk("sync tx ctrl", 11'h002, r);
        $display("test sync transmit done");
        // Table: {twice, mode, rate, filter, enable, ninth, stop}
        for (int i = 0; i < 10; i++)
        begin
            c = cfg[i];
            nine = c[6];
            rb = nine ? c[1] : c[0];
            ok = c[2] && !(c[3] && !rb);
            bc = (c[6:5] == 2'h2) ? (c[4] ? 32 : 64) : 64;
            d = 8'($random(seed));
            rate_double_select <= c[4];
            wr(8'h98, {c[6:5], c[3:2], d[7], !rb, 2'h0});
            fork
                wr(8'h99, d);
                fmsp_remote_node_i.recv_char(nine ? 11 : 10, bc, f);
                begin
                    repeat (3) @(posedge mclk);
                    fmsp_remote_node_i.send_char(~d, nine, c[1], c[0], bc);
                    if (c[7])
                        fmsp_remote_node_i.send_char(d, nine, c[1], c[0], bc);
                end
            join
            repeat (bc) @(posedge mclk);
            chk("tx frame", exp_frame(d, nine, d[7]), f);
            rd(8'h98, r);
            chk("ctrl flags", {c[6:5], c[3:2], d[7], ok ? rb : !rb, 1'b1, ok}, r);
            if (ok)
                last_rx = c[7] ? d : ~d;
            rd(8'h99, r);
            chk("rx buffer", last_rx, r);
            $display("test %0d done", i);
        end
        // Long idle lets the transmit line settle and flags persist
        repeat (2100) @(posedge mclk);
        chk("irq level", 11'h001, serial_irq);
        $display("test idle done");
        end_of_test();
    end

    initial
    begin
        #1000000;
        num_errors++;
        end_of_test();
    end
endmodule : fmsp_port_tb_top

`default_nettype wire
